// ===== src/sleep_ctl_pkg.sv
// Constants and types shared by the sleep entry and wake control block.
// Assumes a single 200 MHz system clock domain.
package sleep_ctl_pkg;
	localparam int PORT_COUNT = 4;
	localparam logic POWERDOWN_RESET = 1'b1;
	localparam logic TIMEOUT_RESET = 1'b1;
	localparam logic IDLE_SELECT_SLEEP = 1'b0;
	localparam logic IDLE_SELECT_IDLE = 1'b1;
	localparam int SYNC_STAGES = 3;

	typedef enum logic [1:0] {
		RUN_ST   = 2'b00,
		SLEEP_ST = 2'b01,
		IDLE_ST  = 2'b10
	} power_state_t;
endpackage

// ===== src/pin_sync.sv
// Three-stage synchroniser with agreement filter for asynchronous inputs.
// Assumes the input is asynchronous to mclk; output changes once stages two and three agree.
`timescale 1ns/1ps
`default_nettype none
module pin_sync
	import sleep_ctl_pkg::*;
(
	// Clock and reset
	input  wire logic mclk,
	input  wire logic rst_n,
	// Pin and filtered level
	input  wire logic pinIn,
	output logic      pinOut
);
	logic [SYNC_STAGES-1:0] stage_r;
	logic [SYNC_STAGES-1:0] stage_nxt;
	logic                   out_r;
	logic                   out_nxt;

	always_comb begin
		stage_nxt = {stage_r[SYNC_STAGES-2:0], pinIn};
		out_nxt = out_r;
		if (stage_r[SYNC_STAGES-2] == stage_r[SYNC_STAGES-1]) begin
			out_nxt = stage_r[SYNC_STAGES-1];
		end
	end

	always_ff @(posedge mclk or negedge rst_n) begin
		if (!rst_n) begin
			stage_r <= '0;
			out_r <= 1'b0;
		end else begin
			stage_r <= stage_nxt;
			out_r <= out_nxt;
		end
	end

	assign pinOut = out_r;
endmodule
`default_nettype wire

// ===== src/sleep_entry_wake_control.sv
// Sleep and Idle entry and wake-up controller for a small microcontroller core.
// Assumes CPU, interrupt and peripheral signals are on mclk; reset-source pins are asynchronous.
// Behaviour
// - Sleep instruction enters Sleep when idle_select is 0, Idle when 1.
// - Sleep leaves reset sources alone; watchdog cleared, keeps counting if enabled and watchdogSleepRun is set.
// - Entering Sleep clears the powerdown flag.
// - Entering Sleep sets the timeout flag.
// - In Sleep the CPU clock and system clock are gated off.
// - Each oscillator keeps running in Sleep if requested or force-enabled.
// - Converter on dedicated RC clock unaffected; otherwise aborted and off, enable kept.
// - In Sleep ports hold drive state unless a connected peripheral is active.
// - Wake on reset pin, brown-out, power-on, watchdog or peripheral interrupt.
// - Pin, brown-out and power-on wake reset; watchdog and interrupt continue execution.
// - Every wake from Sleep clears the watchdog.
// - Enabled and flagged interrupts affect sleep even with global enable clear.
// - Interrupt pending before sleep makes it a no-op; flags and watchdog untouched.
// - Interrupt during sleep completes entry then wakes immediately with all updates.
`timescale 1ns/1ps
`default_nettype none
module sleep_entry_wake_control
	import sleep_ctl_pkg::*;
(
	// Clock and reset
	input  wire logic                  mclk,
	input  wire logic                  rst_n,
	// CPU core
	input  wire logic                  sleepExec,
	input  wire logic                  idleSelect,
	input  wire logic                  flagClear,
	output logic                       cpuClkEn,
	output logic                       sysClkEn,
	output logic                       cpuHalted,
	output logic                       powerdownFlag,
	output logic                       timeoutFlag,
	// Interrupts
	input  wire logic                  intPendingRaw,
	input  wire logic                  globalInterruptEnable,
	output logic                       wakeInterrupt,
	// Reset sources (asynchronous pins)
	input  wire logic                  externalResetPin,
	input  wire logic                  externalResetEnable,
	input  wire logic                  brownoutReset,
	input  wire logic                  brownoutEnable,
	input  wire logic                  powerOnReset,
	output logic                       deviceResetReq,
	// Watchdog
	input  wire logic                  watchdogEvent,
	input  wire logic                  watchdogEnable,
	input  wire logic                  watchdogSleepRun,
	output logic                       watchdogClear,
	output logic                       watchdogRun,
	// Oscillators
	input  wire logic                  lowFreqRequest,
	input  wire logic                  highFreqRequest,
	input  wire logic                  secondaryRequest,
	input  wire logic                  lowFreqForceEnable,
	input  wire logic                  highFreqForceEnable,
	input  wire logic                  secondaryForceEnable,
	output logic                       lowFreqOscEn,
	output logic                       highFreqOscEn,
	output logic                       secondaryOscEn,
	// Converter
	input  wire logic                  converterOn,
	input  wire logic                  converterDedicatedRcClock,
	output logic                       converterAbort,
	output logic                       converterPowerEn,
	// I/O ports
	input  wire logic [PORT_COUNT-1:0] portPeriphActive,
	output logic [PORT_COUNT-1:0]      portHold
);
	logic         extPinS;
	logic         brownS;
	logic         porS;
	logic         resetWake;
	logic         dogWake;
	logic         irqSleepCapable;
	logic         asleep;
	power_state_t state_r;
	power_state_t state_nxt;
	logic         pwrDown_r;
	logic         pwrDown_nxt;
	logic         timeOut_r;
	logic         timeOut_nxt;
	logic         dogClr_r;
	logic         dogClr_nxt;
	logic         wake_r;
	logic         wake_nxt;
	logic         rst_r;
	logic         rst_nxt;

	// Reset sources are asynchronous pins, so each is filtered before use.
	// The price is four to five cycles of extra latency on a reset-type wake.
	pin_sync uExtSync (
		.mclk  (mclk),
		.rst_n (rst_n),
		.pinIn (externalResetPin),
		.pinOut(extPinS)
	);
	pin_sync uBrownSync (
		.mclk  (mclk),
		.rst_n (rst_n),
		.pinIn (brownoutReset),
		.pinOut(brownS)
	);
	pin_sync uPorSync (
		.mclk  (mclk),
		.rst_n (rst_n),
		.pinIn (powerOnReset),
		.pinOut(porS)
	);

	// The interrupt term ignores the global enable on purpose.
	assign irqSleepCapable = intPendingRaw;
	assign resetWake = (extPinS && externalResetEnable) || (brownS && brownoutEnable) || porS;
	assign dogWake = watchdogEvent && watchdogEnable;
	// Idle is deliberately not asleep: ports, oscillators and converter carry on as in Run.
	assign asleep = (state_r == SLEEP_ST);

	always_comb begin
		state_nxt = state_r;
		pwrDown_nxt = pwrDown_r;
		timeOut_nxt = timeOut_r;
		dogClr_nxt = 1'b0;
		wake_nxt = 1'b0;
		rst_nxt = 1'b0;
		if (flagClear) begin
			pwrDown_nxt = POWERDOWN_RESET;
			timeOut_nxt = TIMEOUT_RESET;
		end
		// The case below is decoded after the clear, so an event in the same cycle wins.
		case (state_r)
			RUN_ST: begin
				if (sleepExec && !irqSleepCapable) begin
					// Pending interrupt turns sleep into a no-op.
					dogClr_nxt = 1'b1;
					pwrDown_nxt = 1'b0;
					timeOut_nxt = 1'b1;
					if (idleSelect == IDLE_SELECT_IDLE) begin
						state_nxt = IDLE_ST;
					end else begin
						state_nxt = SLEEP_ST;
					end
				end
			end
			SLEEP_ST, IDLE_ST: begin
				// Interrupt arriving during entry is seen here and wakes at once.
				if (resetWake) begin
					state_nxt = RUN_ST;
					rst_nxt = 1'b1;
					dogClr_nxt = 1'b1;
				end else if (irqSleepCapable || dogWake) begin
					state_nxt = RUN_ST;
					wake_nxt = 1'b1;
					dogClr_nxt = 1'b1;
					if (dogWake) begin
						// A watchdog wake is a time-out, which the timeout flag reports as 0.
						timeOut_nxt = 1'b0;
					end
				end
			end
			default: begin
				state_nxt = RUN_ST;
			end
		endcase
	end

	always_ff @(posedge mclk or negedge rst_n) begin
		if (!rst_n) begin
			state_r <= RUN_ST;
			pwrDown_r <= POWERDOWN_RESET;
			timeOut_r <= TIMEOUT_RESET;
			dogClr_r <= 1'b0;
			wake_r <= 1'b0;
			rst_r <= 1'b0;
		end else begin
			state_r <= state_nxt;
			pwrDown_r <= pwrDown_nxt;
			timeOut_r <= timeOut_nxt;
			dogClr_r <= dogClr_nxt;
			wake_r <= wake_nxt;
			rst_r <= rst_nxt;
		end
	end

	// Clock gating is combinational from state so the cycle of entry already stops the core.
	assign cpuClkEn = (state_r == RUN_ST);
	assign sysClkEn = !asleep;
	assign cpuHalted = (state_r != RUN_ST);
	assign powerdownFlag = pwrDown_r;
	assign timeoutFlag = timeOut_r;
	assign wakeInterrupt = wake_r;
	assign deviceResetReq = rst_r;
	assign watchdogClear = dogClr_r;
	// A watchdog not allowed to run in Sleep only stalls; every wake clears it anyway.
	assign watchdogRun = watchdogEnable && (!asleep || watchdogSleepRun);

	assign lowFreqOscEn = !asleep || lowFreqRequest || lowFreqForceEnable;
	assign highFreqOscEn = !asleep || highFreqRequest || highFreqForceEnable;
	assign secondaryOscEn = !asleep || secondaryRequest || secondaryForceEnable;

	// The converter-on bit itself is not touched; only its power is withdrawn.
	assign converterAbort = asleep && converterOn && !converterDedicatedRcClock;
	assign converterPowerEn = converterOn && (!asleep || converterDedicatedRcClock);

	genvar gi;
	generate
		for (gi = 0; gi < PORT_COUNT; gi++) begin : gPort
			assign portHold[gi] = asleep && !portPeriphActive[gi];
		end
	endgenerate

	AST_ENTRY_FLAGS: assert property (@(posedge mclk) disable iff (!rst_n)
		(state_r == RUN_ST && sleepExec && !intPendingRaw)
		|=> (!powerdownFlag && timeoutFlag && watchdogClear))
		else $error("Sleep entry did not update flags");
	AST_SLEEP_SELECT: assert property (@(posedge mclk) disable iff (!rst_n)
		(state_r == RUN_ST && sleepExec && !intPendingRaw && !idleSelect)
		|=> (state_r == SLEEP_ST))
		else $error("Sleep not entered");
	AST_IDLE_SELECT: assert property (@(posedge mclk) disable iff (!rst_n)
		(state_r == RUN_ST && sleepExec && !intPendingRaw && idleSelect)
		|=> (state_r == IDLE_ST && sysClkEn && !cpuClkEn))
		else $error("Idle not entered");
	AST_NOP_SLEEP: assert property (@(posedge mclk) disable iff (!rst_n)
		(state_r == RUN_ST && sleepExec && intPendingRaw && !flagClear)
		|=> (state_r == RUN_ST && !watchdogClear
			&& $stable(powerdownFlag) && $stable(timeoutFlag)))
		else $error("Pending interrupt did not make sleep a no-op");
	AST_CLOCKS_OFF: assert property (@(posedge mclk) disable iff (!rst_n)
		asleep |-> (!cpuClkEn && !sysClkEn))
		else $error("Clocks running in Sleep");
	AST_IRQ_WAKE: assert property (@(posedge mclk) disable iff (!rst_n)
		(state_r != RUN_ST && intPendingRaw && !resetWake)
		|=> (state_r == RUN_ST && wakeInterrupt && watchdogClear))
		else $error("Interrupt wake failed");
	AST_RESET_WAKE: assert property (@(posedge mclk) disable iff (!rst_n)
		(state_r != RUN_ST && resetWake) |=> (deviceResetReq && !wakeInterrupt))
		else $error("Reset wake did not request reset");
	AST_PORT_HOLD: assert property (@(posedge mclk) disable iff (!rst_n)
		(asleep && !portPeriphActive[0]) |-> portHold[0])
		else $error("Port not held in Sleep");
	AST_CONV_ABORT: assert property (@(posedge mclk) disable iff (!rst_n)
		(asleep && converterDedicatedRcClock) |-> (converterPowerEn == converterOn))
		else $error("RC-clocked converter affected by Sleep");

	// Reset-type wakes must also leave the watchdog cleared and the core running.
	AST_RESET_WAKE_CLR: assert property (@(posedge mclk) disable iff (!rst_n)
		(state_r != RUN_ST && resetWake) |=> (watchdogClear && state_r == RUN_ST))
		else $error("Reset wake left watchdog uncleared");
	AST_DOG_WAKE: assert property (@(posedge mclk) disable iff (!rst_n)
		(state_r != RUN_ST && dogWake && !resetWake)
		|=> (wakeInterrupt && watchdogClear && !deviceResetReq && !timeoutFlag))
		else $error("Watchdog wake failed");
	AST_STAY_ASLEEP: assert property (@(posedge mclk) disable iff (!rst_n)
		(asleep && !resetWake && !dogWake && !intPendingRaw) |=> asleep)
		else $error("Left Sleep without a wake event");
	AST_GIE_IGNORED: assert property (@(posedge mclk) disable iff (!rst_n)
		(state_r != RUN_ST && intPendingRaw && !globalInterruptEnable && !resetWake)
		|=> wakeInterrupt)
		else $error("Interrupt with global enable clear did not wake");

	// Watchdog, oscillators and Idle: what keeps running while the core is halted.
	AST_DOG_SLEEP_STOP: assert property (@(posedge mclk) disable iff (!rst_n)
		(asleep && !watchdogSleepRun) |-> !watchdogRun)
		else $error("Watchdog ran in Sleep without permission");
	AST_OSC_RUN: assert property (@(posedge mclk) disable iff (!rst_n)
		!asleep |-> (lowFreqOscEn && highFreqOscEn && secondaryOscEn))
		else $error("Oscillator stopped outside Sleep");
	AST_OSC_FORCE: assert property (@(posedge mclk) disable iff (!rst_n)
		(asleep && lowFreqForceEnable && highFreqForceEnable && secondaryForceEnable)
		|-> (lowFreqOscEn && highFreqOscEn && secondaryOscEn))
		else $error("Force-enabled oscillator stopped in Sleep");
	AST_IDLE_KEEP: assert property (@(posedge mclk) disable iff (!rst_n)
		(state_r == IDLE_ST) |-> (sysClkEn && cpuHalted && !portHold[0]))
		else $error("Idle stopped the system clock");

	// Converter in Sleep outside the dedicated RC case; ports and abort outside Sleep.
	AST_CONV_OFF: assert property (@(posedge mclk) disable iff (!rst_n)
		(asleep && !converterDedicatedRcClock) |-> !converterPowerEn)
		else $error("Converter kept power in Sleep");
	AST_RUN_NO_HOLD: assert property (@(posedge mclk) disable iff (!rst_n)
		!asleep |-> (portHold == '0 && !converterAbort))
		else $error("Port held outside Sleep");

	COV_SLEEP: cover property (@(posedge mclk) disable iff (!rst_n)
		state_r == RUN_ST ##1 state_r == SLEEP_ST ##[1:20] wakeInterrupt);
	COV_IDLE: cover property (@(posedge mclk) disable iff (!rst_n)
		state_r == IDLE_ST ##[1:20] state_r == RUN_ST);
	COV_NOP: cover property (@(posedge mclk) disable iff (!rst_n)
		state_r == RUN_ST && sleepExec && intPendingRaw);
	COV_RESET: cover property (@(posedge mclk) disable iff (!rst_n) deviceResetReq);
	COV_DOG_WAKE: cover property (@(posedge mclk) disable iff (!rst_n)
		state_r == SLEEP_ST && dogWake ##1 wakeInterrupt);
endmodule
`default_nettype wire

// ===== verif/int_source_model.sv
// Model of the core's interrupt logic: per-source enable and flag bits.
// Assumes the bench drives its controls just after the rising edge of mclk.
`timescale 1ns/1ps
`default_nettype none
module int_source_model (
	// Clock and reset
	input  wire logic       mclk,
	input  wire logic       rst_n,
	// Source control
	input  wire logic [3:0] srcEnable,
	input  wire logic [3:0] flagSet,
	input  wire logic       flagClr,
	// Pending level
	output logic            intPendingRaw
);
	logic [3:0] flagBits_r;
	logic [3:0] flagBits_nxt;

	always_comb begin
		flagBits_nxt = flagClr ? 4'h0 : (flagBits_r | flagSet);
	end

	always_ff @(posedge mclk or negedge rst_n) begin
		if (!rst_n) begin
			flagBits_r <= 4'h0;
		end else begin
			flagBits_r <= flagBits_nxt;
		end
	end

	// The global enable is deliberately not consulted here.
	assign intPendingRaw = |(srcEnable & flagBits_r);
endmodule
`default_nettype wire

// ===== verif/tb_top.sv
// Self-checking bench for the sleep entry and wake controller.
// Assumes a 200 MHz mclk and inputs driven 1 ns after each rising edge.
`timescale 1ns/1ps
`default_nettype none
module tb_top;
	import sleep_ctl_pkg::*;
	logic mclk, rst_n, sleepExec, idleSelect, flagClear, cpuClkEn, sysClkEn, cpuHalted;
	logic powerdownFlag, timeoutFlag, intPendingRaw, globalInterruptEnable, wakeInterrupt;
	logic externalResetPin, externalResetEnable, brownoutReset, brownoutEnable, powerOnReset;
	logic deviceResetReq, watchdogEvent, watchdogEnable, watchdogSleepRun, watchdogClear;
	logic watchdogRun, lowFreqRequest, highFreqRequest, secondaryRequest, lowFreqForceEnable;
	logic highFreqForceEnable, secondaryForceEnable, lowFreqOscEn, highFreqOscEn;
	logic secondaryOscEn, converterOn, converterDedicatedRcClock, converterAbort;
	logic converterPowerEn, flagClr;
	logic [PORT_COUNT-1:0] portPeriphActive, portHold;
	logic [3:0] srcEnable, flagSet;
	int errCount, samplesChecked, n;

	sleep_entry_wake_control i_dut (
		.mclk                     (mclk),
		.rst_n                    (rst_n),
		.sleepExec                (sleepExec),
		.idleSelect               (idleSelect),
		.flagClear                (flagClear),
		.cpuClkEn                 (cpuClkEn),
		.sysClkEn                 (sysClkEn),
		.cpuHalted                (cpuHalted),
		.powerdownFlag            (powerdownFlag),
		.timeoutFlag              (timeoutFlag),
		.intPendingRaw            (intPendingRaw),
		.globalInterruptEnable    (globalInterruptEnable),
		.wakeInterrupt            (wakeInterrupt),
		.externalResetPin         (externalResetPin),
		.externalResetEnable      (externalResetEnable),
		.brownoutReset            (brownoutReset),
		.brownoutEnable           (brownoutEnable),
		.powerOnReset             (powerOnReset),
		.deviceResetReq           (deviceResetReq),
		.watchdogEvent            (watchdogEvent),
		.watchdogEnable           (watchdogEnable),
		.watchdogSleepRun         (watchdogSleepRun),
		.watchdogClear            (watchdogClear),
		.watchdogRun              (watchdogRun),
		.lowFreqRequest           (lowFreqRequest),
		.highFreqRequest          (highFreqRequest),
		.secondaryRequest         (secondaryRequest),
		.lowFreqForceEnable       (lowFreqForceEnable),
		.highFreqForceEnable      (highFreqForceEnable),
		.secondaryForceEnable     (secondaryForceEnable),
		.lowFreqOscEn             (lowFreqOscEn),
		.highFreqOscEn            (highFreqOscEn),
		.secondaryOscEn           (secondaryOscEn),
		.converterOn              (converterOn),
		.converterDedicatedRcClock(converterDedicatedRcClock),
		.converterAbort           (converterAbort),
		.converterPowerEn         (converterPowerEn),
		.portPeriphActive         (portPeriphActive),
		.portHold                 (portHold)
	);
	int_source_model i_int (
		.mclk         (mclk),
		.rst_n        (rst_n),
		.srcEnable    (srcEnable),
		.flagSet      (flagSet),
		.flagClr      (flagClr),
		.intPendingRaw(intPendingRaw)
	);

	initial begin
		mclk = 1'b0;
		forever #2.5 mclk = ~mclk;
	end

	task automatic step;
		@(posedge mclk);
		#1;
	endtask

	task automatic chk(input logic [3:0] got, input logic [3:0] exp);
		samplesChecked++;
		if (got !== exp) begin
			errCount++;
			$display("mismatch %0t got %h expected %h", $time, got, exp);
		end
	endtask

	task automatic doSleep(input logic idl);
		idleSelect = idl;
		sleepExec = 1'b1;
		step;
		sleepExec = 1'b0;
	endtask

	task automatic pulseFlags;
		flagClear = 1'b1;
		step;
		flagClear = 1'b0;
	endtask

	task automatic endOfTest;
		$display("errors %0d checks %0d", errCount, samplesChecked);
		if (errCount == 0 && samplesChecked > 0) begin
			$display("DONE - PASS");
		end else begin
			$display("DONE - FAIL");
		end
		$finish;
	endtask

	// The sequence needs about 75 cycles; 400 cycles leaves room without hiding a hang.
	initial begin
		#2000;
		errCount++;
		endOfTest;
	end

	initial begin
		{rst_n, sleepExec, idleSelect, flagClear, globalInterruptEnable, flagClr} = 6'h0;
		{externalResetPin, externalResetEnable, brownoutReset, brownoutEnable} = 4'h0;
		{powerOnReset, watchdogEvent, watchdogEnable, watchdogSleepRun} = 4'h0;
		{lowFreqRequest, highFreqRequest, secondaryRequest} = 3'h0;
		{lowFreqForceEnable, highFreqForceEnable, secondaryForceEnable} = 3'h0;
		{converterOn, converterDedicatedRcClock} = 2'h0;
		portPeriphActive = 4'h5;
		srcEnable = 4'h1;
		flagSet = 4'h0;
		repeat (10) @(posedge mclk);
		#1 rst_n = 1'b1;
		chk({powerdownFlag, timeoutFlag, cpuClkEn, sysClkEn}, 4'hf);
		repeat (4) step;
		{converterOn, watchdogEnable, watchdogSleepRun} = 3'h7;
		doSleep(IDLE_SELECT_SLEEP);
		chk({powerdownFlag, timeoutFlag}, 4'h1);
		chk({cpuClkEn, sysClkEn, cpuHalted}, 4'h1);
		chk({watchdogClear, watchdogRun}, 4'h3);
		chk(portHold, 4'ha);
		chk({converterAbort, converterPowerEn}, 4'h2);
		converterDedicatedRcClock = 1'b1;
		#1 chk({converterAbort, converterPowerEn}, 4'h1);
		watchdogSleepRun = 1'b0;
		#1 chk(watchdogRun, 4'h0);
		for (n = 0; n < 4; n++) begin
			step;
			{lowFreqRequest, highFreqRequest, secondaryRequest} = {3{n[0]}};
			{lowFreqForceEnable, highFreqForceEnable, secondaryForceEnable} = {3{n[1]}};
			#1 chk({lowFreqOscEn, highFreqOscEn, secondaryOscEn}, {1'b0, {3{n[0] | n[1]}}});
		end
		{watchdogEnable, watchdogEvent} = 2'h1;
		repeat (2) step;
		chk(cpuHalted, 4'h1);
		watchdogEnable = 1'b1;
		step;
		chk({wakeInterrupt, watchdogClear, cpuClkEn, deviceResetReq}, 4'he);
		chk(timeoutFlag, 4'h0);
		watchdogEvent = 1'b0;
		step;
		chk(wakeInterrupt, 4'h0);
		chk(portHold, 4'h0);
		doSleep(IDLE_SELECT_SLEEP);
		flagSet = 4'h1;
		step;
		flagSet = 4'h0;
		step;
		chk({wakeInterrupt, watchdogClear, powerdownFlag, timeoutFlag}, 4'hd);
		pulseFlags;
		doSleep(IDLE_SELECT_SLEEP);
		chk({powerdownFlag, timeoutFlag, cpuHalted, watchdogClear}, 4'hc);
		flagClr = 1'b1;
		step;
		flagClr = 1'b0;
		{lowFreqForceEnable, highFreqForceEnable, secondaryForceEnable} = 3'h0;
		{lowFreqRequest, highFreqRequest, secondaryRequest} = 3'h0;
		doSleep(IDLE_SELECT_IDLE);
		chk({cpuClkEn, sysClkEn, cpuHalted}, 4'h3);
		chk({lowFreqOscEn, highFreqOscEn, secondaryOscEn}, 4'h7);
		flagSet = 4'h1;
		step;
		flagSet = 4'h0;
		step;
		chk({wakeInterrupt, cpuClkEn}, 4'h3);
		flagClr = 1'b1;
		step;
		{flagClr, externalResetEnable, brownoutEnable} = 3'h3;
		for (int k = 0; k < 3; k++) begin
			doSleep(IDLE_SELECT_SLEEP);
			{powerOnReset, brownoutReset, externalResetPin} = 3'h1 << k;
			n = 0;
			while (!deviceResetReq && n < 10) begin
				step;
				n++;
			end
			chk({deviceResetReq, wakeInterrupt, watchdogClear}, 4'h5);
			{powerOnReset, brownoutReset, externalResetPin} = 3'h0;
			repeat (8) step;
		end
		endOfTest;
	end
endmodule
`default_nettype wire
